// ===== hw/fps_defs.svh
// Offsets, register values, opcodes and timing counts of the flash sequencer
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH
// Controller register offsets
`define FPS_OFF_CTRL      7'h60
`define FPS_OFF_TXD       7'h68
`define FPS_OFF_RXD       7'h6C
`define FPS_OFF_SSEL      7'h70
// Control register values: start (inhibit plus queue resets), run, stop
`define FPS_CTRL_START    32'h0000_01E6
`define FPS_CTRL_RUN      32'h0000_0086
`define FPS_CTRL_STOP     32'h0000_0186
// Slave select values
`define FPS_SSEL_ON       32'h0000_0000
`define FPS_SSEL_OFF      32'h0000_0001
// Flash opcodes and filler
`define FPS_OP_WREN       8'h06
`define FPS_OP_SECT       8'hD8
`define FPS_OP_PROG       8'h02
`define FPS_OP_READ       8'h03
`define FPS_DUMMY         8'hFF
// Bytes echoed for opcode and 24-bit address
`define FPS_HDR_BYTES     8'h04
// Status codes
`define FPS_ST_BUSY       2'b00
`define FPS_ST_PASS       2'b01
`define FPS_ST_FAIL       2'b10
`define FPS_ST_HANG       2'b11
// Step timeout
`define FPS_CLK_MHZ       250
`define FPS_TIMEOUT_NS    10000
`define FPS_TIMEOUT_CYC   ((`FPS_TIMEOUT_NS * `FPS_CLK_MHZ) / 1000)
`endif

// ===== hw/fps_pkg.sv
// Types of the flash sequencer
package fps_pkg;
  typedef enum logic [7:0] {
    FPS_IDLE   = 8'b0000_0001,
    FPS_WEN_A  = 8'b0000_0010,
    FPS_ERASE  = 8'b0000_0100,
    FPS_WEN_B  = 8'b0000_1000,
    FPS_PROG   = 8'b0001_0000,
    FPS_READ   = 8'b0010_0000,
    FPS_FETCH  = 8'b0100_0000,
    FPS_FINISH = 8'b1000_0000
  } fps_phase_t;

  typedef enum logic [1:0] {
    FPS_K_NONE  = 2'h0,
    FPS_K_WRITE = 2'h1,
    FPS_K_READ  = 2'h2,
    FPS_K_WAIT  = 2'h3
  } fps_kind_t;

  typedef struct packed {
    fps_kind_t   kind;
    logic [6:0]  addr;
    logic [31:0] data;
    logic        last;
  } fps_step_t;
endpackage : fps_pkg

// ===== hw/fps_fifo_if.sv
// Valid/ready carrier between sequencer and its byte FIFO
`timescale 1ns/1ns
interface fps_fifo_if #(parameter int W = 8);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  modport user (output push_valid, push_data, pop_ready,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
endinterface : fps_fifo_if

// ===== hw/fps_fifo.sv
// Parameterised FIFO holding read-back bytes
`timescale 1ns/1ns
module fps_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn,    // Async reset, active low
  fps_fifo_if.fifo q        // Push and pop sides
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [W-1:0]  out_data;
  logic          out_valid;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          do_push;
  logic          do_pop;
  logic          do_load;

  // Honest full and empty; head word is served from a register
  assign q.push_ready = (count != CW'(D));
  assign q.pop_valid  = out_valid;
  assign q.pop_data   = out_data;
  assign do_push      = q.push_valid & q.push_ready;
  assign do_pop       = out_valid & q.pop_ready;
  assign do_load      = (count != '0) & (!out_valid | do_pop);

  // Storage and registered head word
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_data;
    end
    if (do_load) begin
      out_data <= mem[rd_ptr];
    end
  end

  // Pointers with wrap at depth
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_load) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_load) begin
        out_valid <= 1'b1;
      end else if (do_pop) begin
        out_valid <= 1'b0;
      end
      count <= count + CW'(do_push) - CW'(do_load);
    end
  end
endmodule : fps_fifo

// ===== hw/fps_sequencer.sv
// Flash erase/program/read sequencer driving a SPI controller's registers
//
// Behaviour
// [RL1] Write enable precedes every modifying command
// [RL2] 24-bit addresses, single slave only
// [RL3] Write enable starts with control 0x1E6
// [RL4] Opcode queued before slave select
// [RL5] Select slave with 0x00 before unmasking
// [RL6] Clearing master inhibit starts the shift
// [RL7] Deselect slave with 0x01 after transfer
// [RL8] Each sequence ends re-setting master inhibit
// [RL9] Erase, program, read reset both queues
// [RL10] Erase: opcode then sector or base address
// [RL11] Program: opcode, address, payload within depth
// [RL12] Read: one dummy byte per returned byte
// [RL13] Fetch received bytes after deselect and inhibit
// [RL14] Status low bits: pass, fail, hang
// [RL15] Status bits 9:2 hold stopping index
// [RL16] Done high when check finishes
// [RL17] Wait for empty queue before deselect
// [RL18] Step timeout declares hang, index frozen
`timescale 1ns/1ns
`include "fps_defs.svh"
module fps_sequencer import fps_pkg::*; #(
  parameter int          PLEN        = 4,
  parameter int          FIFO_DEPTH  = 16,
  parameter logic [23:0] FLASH_ADDR  = 24'h00_1000,
  parameter logic [23:0] FLASH_BASE  = 24'h00_0000,
  parameter logic        BULK        = 1'b0,
  parameter logic [7:0]  BULK_OPCODE = 8'hC7,
  parameter logic [7:0]  PAT_SEED    = 8'hA5,
  parameter int          TIMEOUT_CYC = `FPS_TIMEOUT_CYC
) (
  input  wire logic        sys_clk,   // System clock
  input  wire logic        rstn,      // Async reset, active low
  input  wire logic        start,     // Start whole check run
  output logic             reg_req,   // Register access request
  output logic             reg_we,    // 1 write, 0 read
  output logic [6:0]       reg_addr,  // Register offset
  output logic [31:0]      reg_wdata, // Write data
  input  wire logic        reg_ack,   // Access complete
  input  wire logic [31:0] reg_rdata, // Read data, valid with ack
  input  wire logic        tx_empty,  // Controller transmit queue empty
  input  wire logic        xfer_done, // Controller transfer finished
  output logic [9:0]       status,    // Index and result code
  output logic             done       // Check run finished
);
  localparam int CHW = $clog2(PLEN + 1);

  fps_phase_t phase;
  fps_phase_t next_phase;
  fps_step_t  cur;
  logic [7:0] pos;
  logic [15:0] tmo;
  logic [CHW-1:0] chk_cnt;
  logic       hang;
  logic       bad;
  logic       running;
  logic       step_ok;
  logic       issue;

  fps_fifo_if #(.W(8)) rxq ();

  fps_fifo #(.W(8), .D(FIFO_DEPTH)) u_rxq (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .q       (rxq.fifo)
  );

  // Expected payload byte
  function automatic logic [7:0] pattern(input logic [7:0] i);
    pattern = PAT_SEED ^ i;
  endfunction : pattern

  // Micro step of one controller transfer at position p
  function automatic fps_step_t xfer_step(input logic [7:0]  p,
                                          input logic [7:0]  op,
                                          input logic        addr_on,
                                          input logic [7:0]  n,
                                          input logic        dummy,
                                          input logic [23:0] fa);
    fps_step_t  s;
    logic [7:0] base;
    logic [7:0] tail;
    s    = '{kind: FPS_K_WRITE, addr: `FPS_OFF_TXD, data: '0, last: 1'b0};
    base = addr_on ? 8'h05 : 8'h02;
    tail = p - base - n;
    if (p == 8'h00) begin
      s.addr = `FPS_OFF_CTRL;
      s.data = `FPS_CTRL_START; // RL3 RL9
    end else if (p == 8'h01) begin
      s.data = {24'h00_0000, op}; // RL4 RL10
    end else if (p < base) begin
      s.data = {24'h00_0000, fa[8'd23 - (p - 8'h02) * 8'd8 -: 8]}; // RL2 RL10
    end else if (p < base + n) begin
      s.data = {24'h00_0000, dummy ? `FPS_DUMMY : pattern(p - base)}; // RL11 RL12
    end else begin
      unique case (tail)
        8'h00: begin
          s.addr = `FPS_OFF_SSEL;
          s.data = `FPS_SSEL_ON; // RL5
        end
        8'h01: begin
          s.addr = `FPS_OFF_CTRL;
          s.data = `FPS_CTRL_RUN; // RL6
        end
        8'h02: s.kind = FPS_K_WAIT; // RL17
        8'h03: begin
          s.addr = `FPS_OFF_SSEL;
          s.data = `FPS_SSEL_OFF; // RL7
        end
        default: begin
          s.addr = `FPS_OFF_CTRL;
          s.data = `FPS_CTRL_STOP; // RL8
          s.last = 1'b1;
        end
      endcase
    end
    xfer_step = s;
  endfunction : xfer_step

  // Decode current step from phase and position
  always_comb begin
    cur = '{kind: FPS_K_NONE, addr: '0, data: '0, last: 1'b0};
    unique case (phase)
      FPS_WEN_A, FPS_WEN_B: cur = xfer_step(pos, `FPS_OP_WREN, 1'b0, 8'h00, 1'b0, 24'h0);
      FPS_ERASE: cur = xfer_step(pos, BULK ? BULK_OPCODE : `FPS_OP_SECT, 1'b1, 8'h00,
                                 1'b0, BULK ? FLASH_BASE : FLASH_ADDR); // RL10
      FPS_PROG:  cur = xfer_step(pos, `FPS_OP_PROG, 1'b1, 8'(PLEN), 1'b0, FLASH_ADDR);
      FPS_READ:  cur = xfer_step(pos, `FPS_OP_READ, 1'b1, 8'(PLEN), 1'b1, FLASH_ADDR);
      FPS_FETCH: begin
        cur.kind = FPS_K_READ; // RL13
        cur.addr = `FPS_OFF_RXD;
        cur.last = (pos == `FPS_HDR_BYTES + 8'(PLEN) - 8'h01);
      end
      FPS_IDLE, FPS_FINISH: cur = '{kind: FPS_K_NONE, addr: '0, data: '0, last: 1'b0};
    endcase
  end

  // Phase order, write enable before erase and program
  always_comb begin
    unique case (phase)
      FPS_IDLE:   next_phase = FPS_WEN_A;
      FPS_WEN_A:  next_phase = FPS_ERASE; // RL1
      FPS_ERASE:  next_phase = FPS_WEN_B;
      FPS_WEN_B:  next_phase = FPS_PROG; // RL1
      FPS_PROG:   next_phase = FPS_READ;
      FPS_READ:   next_phase = FPS_FETCH;
      FPS_FETCH:  next_phase = FPS_FINISH;
      FPS_FINISH: next_phase = FPS_FINISH;
    endcase
  end

  // Step completion and issue
  assign running = (phase != FPS_IDLE) && (phase != FPS_FINISH) && !hang;
  assign step_ok = running && ((cur.kind == FPS_K_WAIT && tx_empty && xfer_done) ||
                               (reg_req && reg_ack)); // RL6 RL17
  assign issue   = running && !reg_req &&
                   (cur.kind == FPS_K_WRITE || (cur.kind == FPS_K_READ && rxq.push_ready));

  // Captured payload bytes into FIFO, header echoes dropped
  assign rxq.push_valid = step_ok && (phase == FPS_FETCH) && (pos >= `FPS_HDR_BYTES); // RL13
  assign rxq.push_data  = reg_rdata[7:0];
  assign rxq.pop_ready  = !hang && (phase != FPS_IDLE);

  // Register request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_req   <= 1'b0;
      reg_we    <= 1'b0;
      reg_addr  <= '0;
      reg_wdata <= '0;
    end else if (reg_req && (reg_ack || hang)) begin
      reg_req <= 1'b0;
    end else if (issue) begin
      reg_req   <= 1'b1;
      reg_we    <= (cur.kind == FPS_K_WRITE);
      reg_addr  <= cur.addr;
      reg_wdata <= cur.data;
    end
  end

  // Phase and position
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= FPS_IDLE;
      pos   <= '0;
    end else if (start && !running) begin
      phase <= FPS_WEN_A;
      pos   <= '0;
    end else if (step_ok) begin
      pos   <= cur.last ? 8'h00 : pos + 8'h01;
      phase <= cur.last ? next_phase : phase;
    end
  end

  // Step timeout
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tmo  <= '0;
      hang <= 1'b0;
    end else if (start && !running) begin
      tmo  <= '0;
      hang <= 1'b0;
    end else if (!running || step_ok) begin
      tmo <= '0;
    end else if (tmo == 16'(TIMEOUT_CYC - 1)) begin
      hang <= 1'b1; // RL18
    end else begin
      tmo <= tmo + 16'h0001;
    end
  end

  // Compare read-back bytes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chk_cnt <= '0;
      bad     <= 1'b0;
    end else if (start && !running) begin
      chk_cnt <= '0;
      bad     <= 1'b0;
    end else if (rxq.pop_valid && rxq.pop_ready) begin
      chk_cnt <= chk_cnt + 1'b1;
      if (rxq.pop_data != pattern(8'(chk_cnt))) begin
        bad <= 1'b1; // RL14
      end
    end
  end

  // Status word and completion flag
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
      done   <= 1'b0;
    end else if (start && !running) begin
      status <= {8'h00, `FPS_ST_BUSY};
      done   <= 1'b0;
    end else if (hang) begin
      status[1:0] <= `FPS_ST_HANG; // RL14 RL18
    end else if (step_ok) begin
      status[9:2] <= status[9:2] + 8'h01; // RL15
    end else if (phase == FPS_FINISH && !done && chk_cnt == CHW'(PLEN)) begin
      status[1:0] <= bad ? `FPS_ST_FAIL : `FPS_ST_PASS; // RL14
      done        <= 1'b1; // RL16
    end
  end
endmodule : fps_sequencer

// ===== tb/fps_seq_monitor.sv
// Port checks of the flash sequencer
`timescale 1ns/1ns
`include "fps_defs.svh"
module fps_seq_monitor (
  input wire logic        sys_clk,   // Clock
  input wire logic        rstn,      // Reset, active low
  input wire logic        start,     // Run start
  input wire logic        reg_req,   // Request
  input wire logic        reg_we,    // Write
  input wire logic [6:0]  reg_addr,  // Offset
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic        reg_ack,   // Ack
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic        tx_empty,  // Queue empty
  input wire logic        xfer_done, // Shift over
  input wire logic [9:0]  status,    // Index and code
  input wire logic        done       // Finished
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  req_hold_a: assert property (
    reg_req && !reg_ack |=> (reg_req && $stable(reg_addr) && $stable(reg_wdata)
      && $stable(reg_we)) || (!reg_req && status[1:0] == `FPS_ST_HANG))
    else $error("request moved before ack");
  req_gap_a: assert property (
    reg_req && reg_ack |=> !reg_req && status[9:2] == $past(status[9:2]) + 8'h01)
    else $error("no gap or no index step after ack");
  ctrl_value_a: assert property (
    reg_req && reg_we && reg_addr == `FPS_OFF_CTRL |-> reg_wdata inside
      {`FPS_CTRL_START, `FPS_CTRL_RUN, `FPS_CTRL_STOP})
    else $error("bad control value");
  ssel_value_a: assert property (
    reg_req && reg_we && reg_addr == `FPS_OFF_SSEL |-> reg_wdata inside
      {`FPS_SSEL_ON, `FPS_SSEL_OFF})
    else $error("bad select value");
  read_addr_a: assert property (
    reg_req && !reg_we |-> reg_addr == `FPS_OFF_RXD)
    else $error("read of wrong offset");
  hang_freeze_a: assert property (
    status[1:0] == `FPS_ST_HANG && !start |=> $stable(status) && !done && !reg_req)
    else $error("hang not frozen");
  done_code_a: assert property (
    done |-> status[1:0] == `FPS_ST_PASS || status[1:0] == `FPS_ST_FAIL)
    else $error("done without result");
  index_step_a: assert property (
    status[9:2] != $past(status[9:2]) |-> status[9:2] == 8'h00
      || status[9:2] == $past(status[9:2]) + 8'h01)
    else $error("index jumped");
endmodule : fps_seq_monitor
bind fps_sequencer fps_seq_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn), .start(start),
  .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_ack(reg_ack), .reg_rdata(reg_rdata), .tx_empty(tx_empty), .xfer_done(xfer_done),
  .status(status), .done(done));

// ===== tb/fps_ctrl_model.sv
// SPI controller register port with a small flash behind it
`timescale 1ns/1ns
`include "fps_defs.svh"
module fps_ctrl_model (
  input  wire logic        sys_clk,   // Clock
  input  wire logic        rstn,      // Reset, active low
  input  wire logic        reg_req,   // Request
  input  wire logic        reg_we,    // Write
  input  wire logic [6:0]  reg_addr,  // Offset
  input  wire logic [31:0] reg_wdata, // Write data
  output logic             reg_ack,   // Ack pulse
  output logic [31:0]      reg_rdata, // Read data
  output logic             tx_empty,  // Queue empty
  output logic             xfer_done, // Shift over
  input  wire logic [3:0]  lat,       // Ack latency
  input  wire logic        mute,      // Never ack
  input  wire logic        corrupt,   // Spoil first byte
  output logic             order_err  // Sequence broken
);
  logic [7:0] q [32];
  logic [7:0] rx [32];
  logic [7:0] mem [16];
  logic [3:0] cnt;
  logic       ssel_n;
  logic       wen;
  int         n;
  int         rp;
  int         busy;
  assign tx_empty  = (busy <= 2); // Queue drains before the last shift ends
  assign xfer_done = (busy == 0);
  // Shift the queue: echo header, store or return payload
  task automatic xfer();
    int k;
    if (ssel_n) order_err <= 1'b1;
    if (q[0] inside {`FPS_OP_SECT, 8'hC7, `FPS_OP_PROG}) begin
      if (!wen) order_err <= 1'b1;
      wen = 1'b0;
    end
    if (q[0] == `FPS_OP_WREN) wen = 1'b1;
    for (k = 0; k < n; k++) begin
      rx[k] = q[k];
      if (q[0] == `FPS_OP_PROG && k > 3) mem[k-4] = q[k];
      if (q[0] == `FPS_OP_READ && k > 3) rx[k] = mem[k-4] ^ {7'h00, corrupt && k == 4};
    end
    rp = 0;
    busy <= n + 6;
  endtask : xfer
  // Ack after lat cycles, apply access at completion
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_ack <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      order_err <= 1'b0;
      busy <= 0;
      cnt = 4'h0;
      n = 0;
      rp = 0;
      ssel_n = 1'b1;
      wen = 1'b0;
    end else begin
      reg_ack <= 1'b0;
      reg_rdata <= ~reg_rdata; // Bus wanders outside ack
      if (busy > 0) busy <= busy - 1;
      if (reg_req && reg_ack) begin
        cnt = 4'h0;
        if (!reg_we) rp = rp + 1;
        else case (reg_addr)
          `FPS_OFF_CTRL: begin
            if (reg_wdata[6:5] == 2'b11) n = 0;
            if (!reg_wdata[8]) xfer();
          end
          `FPS_OFF_TXD: begin
            if (!ssel_n) order_err <= 1'b1;
            q[n] = reg_wdata[7:0];
            n = n + 1;
          end
          `FPS_OFF_SSEL: begin
            if (busy > 0) order_err <= 1'b1;
            ssel_n = reg_wdata[0];
          end
          default: order_err <= 1'b1;
        endcase
      end else if (reg_req && !mute) begin
        if (cnt == lat) begin
          reg_ack <= 1'b1;
          reg_rdata <= {24'h00_0000, rx[rp]};
        end
        cnt = cnt + 4'h1;
      end else cnt = 4'h0;
    end
  end
endmodule : fps_ctrl_model

// ===== tb/fps_sequencer_tb_top.sv
// Self-checking bench of the flash sequencer
`timescale 1ns/1ns
`include "fps_defs.svh"
module fps_sequencer_tb_top;
  localparam int         PLEN = 4;
  // Steps: write enable 7, erase 10, write enable 7, program and read 10 + PLEN, fetch 4 + PLEN
  localparam logic [7:0] FULL = 8'(7 + 10 + 7 + (10 + PLEN) * 2 + 4 + PLEN);
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        start = 1'b0;
  logic        mute = 1'b0;
  logic        corrupt = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic        reg_req, reg_we, reg_ack, tx_empty, xfer_done, done, order_err;
  logic [6:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [9:0]  status;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #2 sys_clk = ~sys_clk;
  fps_sequencer #(.PLEN(PLEN), .TIMEOUT_CYC(50)) dut (.sys_clk, .rstn, .start, .reg_req,
    .reg_we, .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .tx_empty, .xfer_done, .status, .done);
  fps_ctrl_model u_ctrl (.sys_clk, .rstn, .reg_req, .reg_we, .reg_addr, .reg_wdata, .reg_ack,
    .reg_rdata, .tx_empty, .xfer_done, .lat, .mute, .corrupt, .order_err);
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Start a run, hold start hold cycles, wait for result
  task automatic run(input logic [1:0] code, input logic [7:0] idx, input logic dn,
                     input int hold);
    int i;
    start = 1'b1;
    repeat (hold) @(posedge sys_clk) #1;
    start = 1'b0;
    @(posedge sys_clk) #1;
    for (i = 0; i < 20000 && done !== 1'b1 && status[1:0] !== `FPS_ST_HANG; i++)
      @(posedge sys_clk) #1;
    if (i == 20000) begin
      chk("wait", 10'h3FF, 10'h000);
      print_verdict();
    end
    repeat (4) @(posedge sys_clk) #1;
    chk("status", status, {idx, code});
    chk("done", {9'h000, done}, {9'h000, dn});
    chk("order", {9'h000, order_err}, 10'h000);
  endtask : run
  task automatic t_pass_fast();
    lat = 4'h0;
    run(`FPS_ST_PASS, FULL, 1'b1, 1);
  endtask : t_pass_fast
  // Mute controller: first step times out
  task automatic t_hang();
    mute = 1'b1;
    run(`FPS_ST_HANG, 8'h00, 1'b0, 1);
    mute = 1'b0;
  endtask : t_hang
  // Restart from hang, slow acks, start held into the run
  task automatic t_pass_slow();
    lat = 4'hC;
    run(`FPS_ST_PASS, FULL, 1'b1, 3);
  endtask : t_pass_slow
  // Reset in mid-run clears outputs
  task automatic t_reset_mid();
    lat = 4'h2;
    start = 1'b1;
    @(posedge sys_clk) #1;
    start = 1'b0;
    repeat (40) @(posedge sys_clk) #1;
    rstn = 1'b0;
    @(posedge sys_clk) #1;
    chk("rst status", status, 10'h000);
    chk("rst req", {8'h00, reg_req, done}, 10'h000);
    rstn = 1'b1;
  endtask : t_reset_mid
  task automatic t_fail();
    corrupt = 1'b1;
    run(`FPS_ST_FAIL, FULL, 1'b1, 1);
    corrupt = 1'b0;
  endtask : t_fail
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rstn = 1'b1;
    t_pass_fast();
    t_hang();
    t_pass_slow();
    t_reset_mid();
    t_fail();
    print_verdict();
  end
endmodule : fps_sequencer_tb_top
